// File: asrc_ctrl.sv
// host-side controller that drives an asynchronous 16-bit two-lane sram
// ============================================================
// Summary of operation
// - write spans overlap of chip select and strobe low; ends at first rise.
// - data setup and hold measured against the terminating rising edge.
// - chip select and address stable 7 ns before write end.
// - address valid by write start; may change right after write end.
// - strobe low at least 7 ns; lane enables 7 ns before write end.
// - write data valid 5 ns before write end; zero hold.
// - strobe writes with output enable low last float time plus setup.
// - sample read data no sooner than 10 ns after stable address.
// - allow 5 ns from output enable low before read data is valid.
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [asrc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [asrc_pkg::DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lane_n,
  // user answer
  output logic rsp_valid,
  output logic [asrc_pkg::DATA_W-1:0] rsp_rdata,
  // memory pins
  output logic [asrc_pkg::ADDR_W-1:0] mem_addr,
  output asrc_pkg::asrc_ctrl_s mem_ctrl,
  input wire logic [asrc_pkg::DATA_W-1:0] mem_data_in,
  output logic [asrc_pkg::DATA_W-1:0] mem_data_out,
  output logic mem_data_oe
);
  // ==========================================================
  // state
  asrc_pkg::asrc_state_e state_q;
  logic [asrc_pkg::CNT_W-1:0] cnt_q;
  logic write_q;
  logic [1:0] lane_n_q;

  // elaboration guard: the wait counter must reach the longest wait
  if (asrc_pkg::WRITE_WAIT_CYCLES >= (1 << asrc_pkg::CNT_W) ||
      asrc_pkg::READ_WAIT_CYCLES >= (1 << asrc_pkg::CNT_W)) begin : g_cnt_check
    $error("asrc_ctrl: wait counts exceed counter width");
  end

  assign req_ready = (state_q == asrc_pkg::ST_IDLE);

  // ==========================================================
  // sequencer
  // one idle cycle after each access keeps address changes clear of the
  // ending strobe edge, at the cost of throughput
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= asrc_pkg::ST_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        asrc_pkg::ST_IDLE: begin
          cnt_q <= '0;
          if (req_valid && req_lane_n != 2'h3) begin
            state_q <= req_write ? asrc_pkg::ST_WRITE : asrc_pkg::ST_READ;
          end
        end
        asrc_pkg::ST_READ: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == asrc_pkg::CNT_W'(asrc_pkg::READ_WAIT_CYCLES - 1)) begin
            state_q <= asrc_pkg::ST_DONE;
          end
        end
        asrc_pkg::ST_WRITE: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == asrc_pkg::CNT_W'(asrc_pkg::WRITE_WAIT_CYCLES - 1)) begin
            state_q <= asrc_pkg::ST_DONE;
          end
        end
        asrc_pkg::ST_DONE: state_q <= asrc_pkg::ST_IDLE;
        default: state_q <= asrc_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // address, data and lane latches: held until the write has ended
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mem_addr <= asrc_pkg::ADDR_RESET;
      mem_data_out <= asrc_pkg::DATA_RESET;
      write_q <= 1'b0;
      lane_n_q <= 2'h3;
    end else if (req_ready && req_valid && req_lane_n != 2'h3) begin
      mem_addr <= req_addr;
      mem_data_out <= req_wdata;
      write_q <= req_write;
      lane_n_q <= req_lane_n;
    end
  end

  // ==========================================================
  // pin drive: all strobes registered so they change on clock edges only
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mem_ctrl <= asrc_pkg::CTRL_IDLE;
      mem_data_oe <= 1'b0;
    end else begin
      mem_ctrl <= asrc_pkg::CTRL_IDLE;
      mem_data_oe <= 1'b0;
      if (state_q == asrc_pkg::ST_IDLE && req_valid && req_lane_n != 2'h3) begin
        mem_ctrl.chip_select_n <= 1'b0;
        mem_ctrl.write_strobe_n <= !req_write;
        mem_ctrl.out_enable_n <= req_write;
        mem_ctrl.low_lane_enable_n <= req_lane_n[0];
        mem_ctrl.high_lane_enable_n <= req_lane_n[1];
        mem_data_oe <= req_write;
      end else if (state_q == asrc_pkg::ST_READ || state_q == asrc_pkg::ST_WRITE) begin
        if (!(cnt_q == asrc_pkg::CNT_W'((write_q ? asrc_pkg::WRITE_WAIT_CYCLES
                                                 : asrc_pkg::READ_WAIT_CYCLES) - 1))) begin
          mem_ctrl.chip_select_n <= 1'b0;
          mem_ctrl.write_strobe_n <= !write_q;
          mem_ctrl.out_enable_n <= write_q;
          mem_ctrl.low_lane_enable_n <= lane_n_q[0];
          mem_ctrl.high_lane_enable_n <= lane_n_q[1];
          mem_data_oe <= write_q;
        end else begin
          // chip select and strobe rise together; write data stays driven one cycle
          mem_data_oe <= write_q;
        end
      end
    end
  end

  // ==========================================================
  // read capture at the end of the access window
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= asrc_pkg::DATA_RESET;
    end else begin
      rsp_valid <= 1'b0;
      if (state_q == asrc_pkg::ST_READ &&
          cnt_q == asrc_pkg::CNT_W'(asrc_pkg::READ_WAIT_CYCLES - 1)) begin
        rsp_valid <= 1'b1;
        // unselected lanes read as zero
        rsp_rdata[7:0] <= lane_n_q[0] ? 8'h00 : mem_data_in[7:0];
        rsp_rdata[15:8] <= lane_n_q[1] ? 8'h00 : mem_data_in[15:8];
      end else if (state_q == asrc_pkg::ST_WRITE &&
                   cnt_q == asrc_pkg::CNT_W'(asrc_pkg::WRITE_WAIT_CYCLES - 1)) begin
        rsp_valid <= 1'b1;
      end
    end
  end

  // ==========================================================
  // checks
  // helper: cycles the strobe has stood low, saturating; a repetition count
  // would tie the check to one clock rate
  logic [asrc_pkg::CNT_W-1:0] strobe_len_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n || mem_ctrl.write_strobe_n) begin
      strobe_len_q <= '0;
    end else if (strobe_len_q != '1) begin
      strobe_len_q <= strobe_len_q + 1'b1;
    end
  end

  sequence s_write_open;
    !mem_ctrl.chip_select_n && !mem_ctrl.write_strobe_n;
  endsequence
  sequence s_read_open;
    !mem_ctrl.chip_select_n && !mem_ctrl.out_enable_n && mem_ctrl.write_strobe_n;
  endsequence

  chk_no_contention: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mem_data_oe |-> mem_ctrl.out_enable_n)
    else $error("controller drives data while output enable is low");
  chk_strobe_width: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(mem_ctrl.write_strobe_n) |->
      strobe_len_q >= asrc_pkg::CNT_W'(asrc_pkg::STROBE_CYCLES))
    else $error("write strobe pulse too short");
  chk_write_end_together: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(mem_ctrl.write_strobe_n) |-> $rose(mem_ctrl.chip_select_n))
    else $error("write strobe and chip select do not end together");
  chk_data_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_write_open ##1 mem_ctrl.write_strobe_n |-> mem_data_oe && $stable(mem_data_out))
    else $error("write data not held at write end");
  chk_addr_stable: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !mem_ctrl.chip_select_n |=> $stable(mem_addr))
    else $error("address changed during access");
  chk_read_wait: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rsp_valid && !write_q |-> $past(!mem_ctrl.out_enable_n, 1))
    else $error("read data sampled without output enable");
  chk_idle_deselect: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == asrc_pkg::ST_DONE |-> mem_ctrl.chip_select_n)
    else $error("chip select low while idle");
  chk_access_done: assert property (@(posedge sys_clk) disable iff (!reset_n)
    req_ready && req_valid && req_lane_n != 2'h3 |-> ##[1:16] rsp_valid)
    else $error("access did not complete");
  chk_lane_select: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_write_open |-> !(mem_ctrl.low_lane_enable_n && mem_ctrl.high_lane_enable_n))
    else $error("write opened with no lane enabled");
  chk_write_data: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_write_open |-> mem_data_oe && mem_ctrl.out_enable_n)
    else $error("write data not driven while write is open");
  chk_read_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_read_open |-> !mem_data_oe)
    else $error("controller drives data during a read");
  chk_read_oe_delay: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(mem_ctrl.out_enable_n) |-> !rsp_valid)
    else $error("read answered at the edge that enabled the outputs");
  chk_end_before_answer: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rsp_valid |-> mem_ctrl.chip_select_n)
    else $error("answer given while the access is still open");
endmodule : asrc_ctrl
`default_nettype wire

// File: asrc_pkg.sv
// package for the asynchronous sram access controller: timing and types
package asrc_pkg;
  // ==========================================================
  // clock
  localparam int unsigned CLK_PERIOD_PS = 20000;
  // ==========================================================
  // device timing, picoseconds, least values
  localparam int unsigned READ_CYCLE_PS = 10000;
  localparam int unsigned OE_TO_DATA_PS = 5000;
  localparam int unsigned SELECT_TO_WRITE_END_PS = 7000;
  localparam int unsigned ADDR_TO_WRITE_END_PS = 7000;
  localparam int unsigned STROBE_PULSE_WIDTH_PS = 7000;
  localparam int unsigned LANE_ENABLE_TO_WRITE_END_PS = 7000;
  localparam int unsigned WRITE_DATA_SETUP_PS = 5000;
  localparam int unsigned STROBE_FALL_FLOAT_PS = 5000;
  // ==========================================================
  // cycle counts, least times rounded up, at least one cycle
  function automatic int unsigned cyc_up(input int unsigned ps);
    int unsigned c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up
  localparam int unsigned READ_CYCLES = cyc_up(READ_CYCLE_PS);
  localparam int unsigned OE_DATA_CYCLES = cyc_up(OE_TO_DATA_PS);
  localparam int unsigned READ_WAIT_CYCLES =
    (READ_CYCLES > OE_DATA_CYCLES) ? READ_CYCLES : OE_DATA_CYCLES;
  localparam int unsigned STROBE_CYCLES = cyc_up(STROBE_PULSE_WIDTH_PS);
  localparam int unsigned SETUP_SUM_CYCLES = cyc_up(STROBE_FALL_FLOAT_PS + WRITE_DATA_SETUP_PS);
  localparam int unsigned WRITE_WAIT_CYCLES =
    (STROBE_CYCLES > SETUP_SUM_CYCLES) ? STROBE_CYCLES : SETUP_SUM_CYCLES;
  localparam int unsigned CNT_W = 4;
  // ==========================================================
  // widths and reset values
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned DATA_W = 16;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
  // ==========================================================
  // types
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_DONE} asrc_state_e;
  typedef struct packed {
    logic chip_select_n;
    logic out_enable_n;
    logic write_strobe_n;
    logic low_lane_enable_n;
    logic high_lane_enable_n;
  } asrc_ctrl_s;
  localparam asrc_ctrl_s CTRL_IDLE = 5'h1F;
endpackage : asrc_pkg

// File: asrc_sram_model.sv
// behavioural model of the two-lane asynchronous static memory
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model (
  // memory pins
  input wire logic [asrc_pkg::ADDR_W-1:0] mem_addr,
  input wire asrc_pkg::asrc_ctrl_s mem_ctrl,
  input wire logic [asrc_pkg::DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe,
  output logic [asrc_pkg::DATA_W-1:0] mem_data_in,
  // tally of timing and contention faults
  output logic [7:0] fault_cnt
);
  // every address backed by a plain array; a sparse map is not taken everywhere
  logic [15:0] store [0:(1 << asrc_pkg::ADDR_W) - 1];
  logic [15:0] word, lat_data;
  logic [18:0] lat_addr;
  logic [1:0] drive, lat_lane_n;
  logic [7:0] clash_faults = 8'h00;
  logic [7:0] timing_faults = 8'h00;
  logic wr_end;
  logic active = 1'b0;
  realtime t_start, t_data;
  assign wr_end = mem_ctrl.chip_select_n | mem_ctrl.write_strobe_n;
  assign fault_cnt = clash_faults + timing_faults;
  always @* begin
    word = store[mem_addr];
    // reads only; deselect, write or output disable float at once
    drive = (!mem_ctrl.chip_select_n && !mem_ctrl.out_enable_n && mem_ctrl.write_strobe_n) ?
      ~{mem_ctrl.high_lane_enable_n, mem_ctrl.low_lane_enable_n} : 2'h0;
    // undriven lanes show the controller's data while it drives, else the inverse of the stored word, never a convenient stale value
    for (int i = 0; i < 2; i++) begin
      mem_data_in[8*i+:8] = drive[i] ? word[8*i+:8] :
        (mem_data_oe ? mem_data_out[8*i+:8] : ~word[8*i+:8]);
    end
  end
  always @(posedge mem_data_oe or posedge drive[0] or posedge drive[1]) begin
    #0.1 if (mem_data_oe && |drive) clash_faults++;
  end
  always @(mem_data_out) t_data = $realtime;
  // zero hold: latch during the overlap so the ending edge may move everything
  always @* if (!wr_end) {lat_addr, lat_data, lat_lane_n} =
    {mem_addr, mem_data_oe ? mem_data_out : ~mem_data_out,
     mem_ctrl.low_lane_enable_n, mem_ctrl.high_lane_enable_n};
  // write spans the overlap and ends at the first rise
  always @(wr_end) begin
    if (wr_end === 1'b0) begin
      t_start = $realtime;
      active = 1'b1;
    end else if (wr_end === 1'b1 && active) begin
      if ($realtime - t_start < 7.0 || $realtime - t_data < 5.0) timing_faults++;
      if (!lat_lane_n[1]) store[lat_addr][7:0] = lat_data[7:0];
      if (!lat_lane_n[0]) store[lat_addr][15:8] = lat_data[15:8];
      active = 1'b0;
    end
  end
endmodule : asrc_sram_model
`default_nettype wire

// File: asrc_ctrl_tb.sv
// self-checking bench for the asynchronous sram access controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module asrc_ctrl_tb;
  logic sys_clk, reset_n, req_valid, req_ready, req_write, rsp_valid, mem_data_oe;
  logic [asrc_pkg::ADDR_W-1:0] req_addr, mem_addr;
  logic [asrc_pkg::DATA_W-1:0] req_wdata, rsp_rdata, mem_data_in, mem_data_out;
  logic [1:0] req_lane_n;
  logic [7:0] fault_cnt;
  asrc_pkg::asrc_ctrl_s mem_ctrl;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  asrc_ctrl DUT (.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_lane_n(req_lane_n), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mem_addr(mem_addr), .mem_ctrl(mem_ctrl), .mem_data_in(mem_data_in),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
  asrc_sram_model MEM (.mem_addr(mem_addr), .mem_ctrl(mem_ctrl), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in), .fault_cnt(fault_cnt));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // run needs about sixty cycles; ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ==========================================================
  // one access, judged at every cycle of its walk
  task automatic op(input logic w, input logic [18:0] a, input logic [15:0] d,
                    input logic [1:0] ln, input logic [15:0] ex);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lane_n <= ln;
    #1;
    for (int i = 0; i < 8 && req_ready !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    `CHK("pins", {1'b0, w, !w, ln[0], ln[1]}, mem_ctrl)
    `CHK("addr", a, mem_addr)
    `CHK("drive", w, mem_data_oe)
    if (w) `CHK("wdata", d, mem_data_out)
    @(posedge sys_clk);
    #1;
    `CHK("answer", 1'b1, rsp_valid)
    `CHK("end_cs_we", 2'h3, {mem_ctrl.chip_select_n, mem_ctrl.write_strobe_n})
    `CHK("hold", w, mem_data_oe)
    if (!w) `CHK("rdata", ex, rsp_rdata)
    @(posedge sys_clk);
    #1;
    `CHK("release", 1'b0, mem_data_oe)
    `CHK("ready", 1'b1, req_ready)
  endtask : op
  // ==========================================================
  // scenarios
  task automatic t_refuse();
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_lane_n <= 2'h3;
    repeat (4) begin
      @(posedge sys_clk);
      #1;
      `CHK("idle_pins", asrc_pkg::CTRL_IDLE, mem_ctrl)
    end
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    `CHK("no_answer", 1'b0, rsp_valid)
  endtask : t_refuse
  // reset in mid-run: pins and registers return to rest, stored words survive
  task automatic t_reset_mid();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("rst_pins", asrc_pkg::CTRL_IDLE, mem_ctrl)
    `CHK("rst_addr", asrc_pkg::ADDR_RESET, mem_addr)
    `CHK("rst_oe", 1'b0, mem_data_oe)
    `CHK("rst_answer", 1'b0, rsp_valid)
    `CHK("rst_rdata", asrc_pkg::DATA_RESET, rsp_rdata)
    @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask : t_reset_mid
  task automatic t_lane_writes();
    op(1'b1, 19'h00123, 16'hA55A, 2'h0, 16'h0000);
    op(1'b1, 19'h00123, 16'h1234, 2'h2, 16'h0000);
    op(1'b1, 19'h00123, 16'h56CD, 2'h1, 16'h0000);
    op(1'b1, 19'h7FFFF, 16'hFFFF, 2'h0, 16'h0000);
    op(1'b0, 19'h00123, 16'h0000, 2'h0, 16'h5634);
  endtask : t_lane_writes
  task automatic t_lane_reads();
    op(1'b0, 19'h00123, 16'h0000, 2'h2, 16'h0034);
    op(1'b0, 19'h00123, 16'h0000, 2'h1, 16'h5600);
    op(1'b0, 19'h7FFFF, 16'h0000, 2'h0, 16'hFFFF);
  endtask : t_lane_reads
  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 19'h00000;
    req_wdata = 16'h0000;
    req_lane_n = 2'h3;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1;
    `CHK("reset_pins", asrc_pkg::CTRL_IDLE, mem_ctrl)
    t_refuse();
    t_lane_writes();
    t_reset_mid();
    t_lane_reads();
    `CHK("model_faults", 8'h00, fault_cnt)
    end_of_test();
  end
endmodule : asrc_ctrl_tb
`default_nettype wire
